// file: design/pmer_cfg.svh
// Offsets, reset values, field positions and timing figures of the NVM reprogram block.
// Assumes inclusion by bare name from the package, NVM store and top design files and from the test files; the guard makes that safe.
`ifndef PMER_CFG_SVH
`define PMER_CFG_SVH

// ****************************************
// Bus address and register offsets
// ****************************************
`define PMER_I2C_ADDR 7'h24
`define PMER_OFF_KEY 8'h0B
`define PMER_OFF_BUCK1 8'h0E
`define PMER_OFF_BUCK2 8'h0F
`define PMER_OFF_BUCK3 8'h10
`define PMER_OFF_SLEW 8'h11
`define PMER_OFF_LIN1 8'h12
`define PMER_OFF_LIN2 8'h13
`define PMER_OFF_SW1 8'h14
`define PMER_OFF_SW2 8'h15
`define PMER_OFF_EN 8'h16
`define PMER_OFF_UVTH 8'h18
`define PMER_OFF_SEQUENCE_CFG_1 8'h19
`define PMER_OFF_SEQUENCE_CFG_2 8'h1A
`define PMER_OFF_SEQUENCE_CFG_3 8'h1B
`define PMER_OFF_SEQUENCE_CFG_4 8'h1C
`define PMER_OFF_SEQUENCE_CFG_5 8'h1D
`define PMER_OFF_SEQUENCE_CFG_6 8'h1E
`define PMER_OFF_TEST 8'h2C
`define PMER_OFF_NSW1 8'h49
`define PMER_OFF_NSW2 8'h4A
`define PMER_OFF_NCHG 8'h4B

// ****************************************
// Factory values and nonvolatile bit masks
// ****************************************
`define PMER_DEF_KEY 8'h00
`define PMER_DEF_TEST 8'h00
`define PMER_DEF_BUCK1 8'h12
`define PMER_DEF_BUCK2 8'h08
`define PMER_DEF_BUCK3 8'h08
`define PMER_DEF_SLEW 8'h06
`define PMER_DEF_LIN1 8'h09
`define PMER_DEF_LIN2 8'h38
`define PMER_DEF_SW1 8'h26
`define PMER_DEF_SW2 8'h3F
`define PMER_DEF_EN 8'h7F
`define PMER_DEF_UVTH 8'h00
`define PMER_DEF_SEQUENCE_CFG_1 8'h15
`define PMER_DEF_SEQUENCE_CFG_2 8'h5F
`define PMER_DEF_SEQUENCE_CFG_3 8'h32
`define PMER_DEF_SEQUENCE_CFG_4 8'h40
`define PMER_DEF_SEQUENCE_CFG_5 8'h20
`define PMER_DEF_SEQUENCE_CFG_6 8'h00
`define PMER_DEF_NSW1 8'h18
`define PMER_DEF_NSW2 8'h18
`define PMER_DEF_NCHG 8'h31
`define PMER_MASK_BUCK1 8'hFE
`define PMER_MASK_BUCK2 8'hFE
`define PMER_MASK_SLEW 8'hBF
`define PMER_MASK_FULL 8'hFF

// ****************************************
// Fields and timing
// ****************************************
`define PMER_KEY_XOR 8'h7D
`define PMER_PROG_BIT 4
`define PMER_BUSY_BIT 7
`define PMER_EN_BIT_BUCK1 4
`define PMER_EN_BIT_BUCK2 3
`define PMER_EN_BIT_BUCK3 2
`define PMER_EN_BIT_LIN1 1
`define PMER_EN_BIT_LIN2 0
`define PMER_EN_BIT_LIN3 6
`define PMER_EN_BIT_SW2 5
`define PMER_SEQ_EXCLUDED 4'h0
`define PMER_SEQ_LAST 4'hF
`define PMER_CLK_MHZ 100
`define PMER_PROG_TIME_US 5000
`define PMER_STROBE_TIME_US 1000

`endif

// file: design/pmer_pkg.sv
// Types and slot tables shared by the NVM reprogram block.
// Assumes the configuration header is on the include path.
`include "pmer_cfg.svh"

package pmer_pkg;
	localparam int PMER_NSLOT = 19;
	localparam int PMER_NRAIL = 7;
	localparam int PMER_SLOT_EN = 8;
	localparam int PMER_SLOT_SEQUENCE_CFG_1 = 10;
	localparam int PMER_SLOT_SEQUENCE_CFG_2 = 11;
	localparam int PMER_SLOT_SEQUENCE_CFG_3 = 12;
	localparam int PMER_SLOT_SEQUENCE_CFG_4 = 13;

	typedef logic [7:0] pmer_byte_t;
	typedef pmer_byte_t [PMER_NSLOT-1:0] pmer_image_t;

	typedef struct packed {
		logic [3:0] buck1_strobe_select;
		logic [3:0] buck2_strobe_select;
		logic [3:0] buck3_strobe_select;
		logic [3:0] linreg1_strobe_select;
		logic [3:0] linreg2_strobe_select;
		logic [3:0] linreg3_strobe_select;
		logic [3:0] second_switch_rail;
	} pmer_rail_strobe_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} pmer_bus_evt_t;

	typedef struct packed {
		logic stb;
		pmer_byte_t off;
		pmer_byte_t data;
	} pmer_wr_t;

	typedef enum logic [3:0] {
		I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WBYTE, I2C_WACK, I2C_RDATA, I2C_RACK
	} pmer_i2c_state_t;

	localparam pmer_byte_t PMER_SLOT_OFF [PMER_NSLOT] = '{
		`PMER_OFF_BUCK1, `PMER_OFF_BUCK2, `PMER_OFF_BUCK3, `PMER_OFF_SLEW, `PMER_OFF_LIN1,
		`PMER_OFF_LIN2, `PMER_OFF_SW1, `PMER_OFF_SW2, `PMER_OFF_EN, `PMER_OFF_UVTH,
		`PMER_OFF_SEQUENCE_CFG_1, `PMER_OFF_SEQUENCE_CFG_2, `PMER_OFF_SEQUENCE_CFG_3, `PMER_OFF_SEQUENCE_CFG_4, `PMER_OFF_SEQUENCE_CFG_5,
		`PMER_OFF_SEQUENCE_CFG_6, `PMER_OFF_NSW1, `PMER_OFF_NSW2, `PMER_OFF_NCHG};
	localparam pmer_byte_t PMER_SLOT_DEF [PMER_NSLOT] = '{
		`PMER_DEF_BUCK1, `PMER_DEF_BUCK2, `PMER_DEF_BUCK3, `PMER_DEF_SLEW, `PMER_DEF_LIN1,
		`PMER_DEF_LIN2, `PMER_DEF_SW1, `PMER_DEF_SW2, `PMER_DEF_EN, `PMER_DEF_UVTH,
		`PMER_DEF_SEQUENCE_CFG_1, `PMER_DEF_SEQUENCE_CFG_2, `PMER_DEF_SEQUENCE_CFG_3, `PMER_DEF_SEQUENCE_CFG_4, `PMER_DEF_SEQUENCE_CFG_5,
		`PMER_DEF_SEQUENCE_CFG_6, `PMER_DEF_NSW1, `PMER_DEF_NSW2, `PMER_DEF_NCHG};
	localparam pmer_byte_t PMER_SLOT_MASK [PMER_NSLOT] = '{
		`PMER_MASK_BUCK1, `PMER_MASK_BUCK2, `PMER_MASK_FULL, `PMER_MASK_SLEW,
		`PMER_MASK_FULL, `PMER_MASK_FULL, `PMER_MASK_FULL, `PMER_MASK_FULL,
		`PMER_MASK_FULL, `PMER_MASK_FULL, `PMER_MASK_FULL, `PMER_MASK_FULL,
		`PMER_MASK_FULL, `PMER_MASK_FULL, `PMER_MASK_FULL, `PMER_MASK_FULL,
		`PMER_MASK_FULL, `PMER_MASK_FULL, `PMER_MASK_FULL};
	// Slots reloaded by an undervoltage reset: converter and regulator setpoints
	localparam logic [PMER_NSLOT-1:0] PMER_SLOT_RAIL = 19'h000F7;
	// Enable register bit of each rail, in strobe struct order (first field first)
	localparam int PMER_RAIL_EN_BIT [PMER_NRAIL] = '{
		`PMER_EN_BIT_BUCK1, `PMER_EN_BIT_BUCK2, `PMER_EN_BIT_BUCK3, `PMER_EN_BIT_LIN1,
		`PMER_EN_BIT_LIN2, `PMER_EN_BIT_LIN3, `PMER_EN_BIT_SW2};
endpackage

// file: design/pmer_nvm.sv
// Nonvolatile image store with a timed commit of the EEPROM-backed registers.
// Assumes commit_i is a one-cycle pulse from logic on the same clock.
`include "pmer_cfg.svh"

module pmer_nvm
	import pmer_pkg::*;
#(
	parameter int PROG_CYCLES = `PMER_PROG_TIME_US * `PMER_CLK_MHZ
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Commit request
	input wire logic commit_i,
	input wire pmer_image_t image_i,
	// Stored image
	output pmer_image_t image_o,
	output logic busy_o
);
	pmer_image_t nvm_ff;
	pmer_image_t nxt_nvm;
	pmer_image_t snap_ff;
	pmer_image_t nxt_snap;
	logic busy_ff;
	logic nxt_busy;
	logic [31:0] tmr_ff;
	logic [31:0] nxt_tmr;

	// ****************************************
	// Commit timer
	// ****************************************
	// Snapshot at the start so edits during the write cannot tear the image
	always_comb begin
		nxt_nvm = nvm_ff;
		nxt_snap = snap_ff;
		nxt_busy = busy_ff;
		nxt_tmr = tmr_ff;
		if (busy_ff) begin
			if (tmr_ff == 32'(PROG_CYCLES - 1)) begin
				nxt_nvm = snap_ff;
				nxt_busy = 1'b0;
			end else begin
				nxt_tmr = tmr_ff + 32'h1;
			end
		end else if (commit_i) begin
			nxt_snap = image_i;
			nxt_busy = 1'b1;
			nxt_tmr = 32'h0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < PMER_NSLOT; i++) begin
				nvm_ff[i] <= PMER_SLOT_DEF[i];
				snap_ff[i] <= PMER_SLOT_DEF[i];
			end
			busy_ff <= 1'b0;
			tmr_ff <= 32'h0;
		end else begin
			nvm_ff <= nxt_nvm;
			snap_ff <= nxt_snap;
			busy_ff <= nxt_busy;
			tmr_ff <= nxt_tmr;
		end
	end

	assign image_o = nvm_ff;
	assign busy_o = busy_ff;
endmodule // pmer_nvm

// file: design/pmer_top.sv
// Register side of a power-manager NVM reprogram path: I2C slave, protected
// register file, EEPROM commit, undervoltage reload and strobe sequencer.
// Assumes scl/sda and the supervisor inputs are asynchronous pins.
`include "pmer_cfg.svh"

module pmer_top
	import pmer_pkg::*;
#(
	parameter int PROG_CYCLES = `PMER_PROG_TIME_US * `PMER_CLK_MHZ,
	parameter int STROBE_CYCLES = `PMER_STROBE_TIME_US * `PMER_CLK_MHZ
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// I2C pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Supervisor and power events
	input wire logic uv_fault_i,
	input wire logic power_cycle_i,
	input wire logic power_on_i,
	// Rail control
	output logic [PMER_NRAIL-1:0] rail_on_o,
	output pmer_rail_strobe_t rail_strobe_o,
	output pmer_image_t live_regs_o,
	output logic prog_mode_o,
	output logic nvm_busy_o
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic [4:0] prev_ff;
	pmer_bus_evt_t evt;
	logic uv_rise;
	logic pwr_rise;
	logic pwr_on;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_ff <= 5'h03;
			sync2_ff <= 5'h03;
			prev_ff <= 5'h03;
		end else begin
			sync1_ff <= {power_on_i, power_cycle_i, uv_fault_i, sda_i, scl_i};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	always_comb begin
		evt.rise = sync2_ff[0] & ~prev_ff[0];
		evt.fall = ~sync2_ff[0] & prev_ff[0];
		evt.start = sync2_ff[0] & prev_ff[0] & prev_ff[1] & ~sync2_ff[1];
		evt.stop = sync2_ff[0] & prev_ff[0] & ~prev_ff[1] & sync2_ff[1];
		evt.sda = sync2_ff[1];
	end
	assign uv_rise = sync2_ff[2] & ~prev_ff[2];
	assign pwr_rise = sync2_ff[3] & ~prev_ff[3];
	assign pwr_on = sync2_ff[4];

	// ****************************************
	// Register read mux
	// ****************************************
	pmer_image_t vol_ff;
	pmer_byte_t key_ff;
	logic prog_ff;
	logic nvm_busy;
	pmer_byte_t ptr_ff;
	pmer_byte_t rd_data;

	always_comb begin
		rd_data = 8'h00;
		if (ptr_ff == `PMER_OFF_KEY) begin
			rd_data = key_ff;
		end else if (ptr_ff == `PMER_OFF_TEST) begin
			rd_data[`PMER_PROG_BIT] = prog_ff;
			rd_data[`PMER_BUSY_BIT] = nvm_busy;
		end
		for (int i = 0; i < PMER_NSLOT; i++) begin
			if (ptr_ff == PMER_SLOT_OFF[i]) begin
				rd_data = vol_ff[i];
			end
		end
	end

	// ****************************************
	// I2C slave
	// ****************************************
	pmer_i2c_state_t state_ff;
	pmer_i2c_state_t nxt_state;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	pmer_byte_t sh_ff;
	pmer_byte_t nxt_sh;
	pmer_byte_t rsh_ff;
	pmer_byte_t nxt_rsh;
	pmer_byte_t nxt_ptr;
	logic rw_ff;
	logic nxt_rw;
	logic first_ff;
	logic nxt_first;
	logic nack_ff;
	logic nxt_nack;
	logic oe_ff;
	logic nxt_oe;
	pmer_wr_t wr_ff;
	pmer_wr_t nxt_wr;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_rsh = rsh_ff;
		nxt_ptr = ptr_ff;
		nxt_rw = rw_ff;
		nxt_first = first_ff;
		nxt_nack = nack_ff;
		nxt_oe = oe_ff;
		nxt_wr = '0;
		if (evt.stop) begin
			nxt_state = I2C_IDLE;
			nxt_oe = 1'b0;
		end else if (evt.start) begin
			nxt_state = I2C_ADDR;
			nxt_cnt = 4'h0;
			nxt_oe = 1'b0;
		end else begin
			case (state_ff)
				I2C_ADDR, I2C_WBYTE: begin
					if (evt.rise) begin
						nxt_sh = {sh_ff[6:0], evt.sda};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (evt.fall && cnt_ff == 4'h8) begin
						nxt_cnt = 4'h0;
						if (state_ff == I2C_WBYTE) begin
							nxt_oe = 1'b1;
							nxt_state = I2C_WACK;
							if (first_ff) begin
								nxt_ptr = sh_ff;
							end else begin
								nxt_wr = '{stb: 1'b1, off: ptr_ff, data: sh_ff};
								nxt_ptr = 8'(ptr_ff + 8'h1);
							end
						end else if (sh_ff[7:1] == `PMER_I2C_ADDR) begin
							nxt_oe = 1'b1;
							nxt_rw = sh_ff[0];
							nxt_state = I2C_AACK;
						end else begin
							nxt_state = I2C_IDLE;
						end
					end
				end
				I2C_AACK, I2C_WACK: begin
					if (evt.fall) begin
						nxt_cnt = 4'h0;
						if (state_ff == I2C_AACK && rw_ff) begin
							nxt_rsh = rd_data;
							nxt_oe = ~rd_data[7];
							nxt_state = I2C_RDATA;
						end else begin
							nxt_oe = 1'b0;
							nxt_first = (state_ff == I2C_AACK);
							nxt_state = I2C_WBYTE;
						end
					end
				end
				I2C_RDATA: begin
					if (evt.rise) begin
						nxt_cnt = cnt_ff + 4'h1;
					end else if (evt.fall) begin
						if (cnt_ff == 4'h8) begin
							nxt_oe = 1'b0;
							nxt_state = I2C_RACK;
						end else begin
							nxt_rsh = {rsh_ff[6:0], 1'b0};
							nxt_oe = ~rsh_ff[6];
						end
					end
				end
				I2C_RACK: begin
					if (evt.rise) begin
						nxt_nack = evt.sda;
						nxt_ptr = 8'(ptr_ff + 8'h1);
					end else if (evt.fall) begin
						nxt_cnt = 4'h0;
						if (nack_ff) begin
							nxt_state = I2C_IDLE;
						end else begin
							nxt_rsh = rd_data;
							nxt_oe = ~rd_data[7];
							nxt_state = I2C_RDATA;
						end
					end
				end
				default: begin
					nxt_state = I2C_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= I2C_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			rsh_ff <= 8'h00;
			ptr_ff <= 8'h00;
			rw_ff <= 1'b0;
			first_ff <= 1'b0;
			nack_ff <= 1'b0;
			oe_ff <= 1'b0;
			wr_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			rsh_ff <= nxt_rsh;
			ptr_ff <= nxt_ptr;
			rw_ff <= nxt_rw;
			first_ff <= nxt_first;
			nack_ff <= nxt_nack;
			oe_ff <= nxt_oe;
			wr_ff <= nxt_wr;
		end
	end

	// ****************************************
	// Protected register file
	// ****************************************
	pmer_image_t nxt_vol;
	pmer_image_t nvm_image;
	pmer_byte_t nxt_key;
	logic nxt_prog;
	logic commit_ff;
	logic nxt_commit;
	logic unlocked;

	assign unlocked = (key_ff == (wr_ff.off ^ `PMER_KEY_XOR));

	// A key is spent by the next write of any kind, so a stale key cannot open
	// a second register
	always_comb begin
		nxt_vol = vol_ff;
		nxt_key = key_ff;
		nxt_prog = prog_ff;
		nxt_commit = 1'b0;
		if (uv_rise) begin
			nxt_key = `PMER_DEF_KEY;
			for (int i = 0; i < PMER_NSLOT; i++) begin
				if (PMER_SLOT_RAIL[i]) begin
					nxt_vol[i] = (nvm_image[i] & PMER_SLOT_MASK[i]) |
						(PMER_SLOT_DEF[i] & ~PMER_SLOT_MASK[i]);
				end
			end
		end else if (pwr_rise) begin
			nxt_key = `PMER_DEF_KEY;
			nxt_prog = 1'b0;
			for (int i = 0; i < PMER_NSLOT; i++) begin
				nxt_vol[i] = (nvm_image[i] & PMER_SLOT_MASK[i]) |
					(PMER_SLOT_DEF[i] & ~PMER_SLOT_MASK[i]);
			end
		end else if (wr_ff.stb) begin
			if (wr_ff.off == `PMER_OFF_KEY) begin
				nxt_key = wr_ff.data;
			end else begin
				nxt_key = `PMER_DEF_KEY;
				if (unlocked) begin
					if (wr_ff.off == `PMER_OFF_TEST) begin
						nxt_prog = wr_ff.data[`PMER_PROG_BIT];
						nxt_commit = wr_ff.data[`PMER_PROG_BIT] & ~prog_ff;
					end
					for (int i = 0; i < PMER_NSLOT; i++) begin
						if (wr_ff.off == PMER_SLOT_OFF[i] && !nvm_busy) begin
							nxt_vol[i] = wr_ff.data;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < PMER_NSLOT; i++) begin
				vol_ff[i] <= PMER_SLOT_DEF[i];
			end
			key_ff <= `PMER_DEF_KEY;
			prog_ff <= 1'b0;
			commit_ff <= 1'b0;
		end else begin
			vol_ff <= nxt_vol;
			key_ff <= nxt_key;
			prog_ff <= nxt_prog;
			commit_ff <= nxt_commit;
		end
	end

	pmer_nvm #(
		.PROG_CYCLES(PROG_CYCLES)
	) u_nvm (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.commit_i(commit_ff),
		.image_i(vol_ff),
		.image_o(nvm_image),
		.busy_o(nvm_busy)
	);

	// ****************************************
	// Strobe sequencer
	// ****************************************
	// Steps up while power is requested and down otherwise, so turn-off runs
	// in the reverse order of turn-on
	pmer_rail_strobe_t strobe;
	logic [3:0] step_ff;
	logic [3:0] nxt_step;
	logic [31:0] stmr_ff;
	logic [31:0] nxt_stmr;
	logic [PMER_NRAIL-1:0] rail_ff;
	logic [PMER_NRAIL-1:0] nxt_rail;
	logic [PMER_NRAIL*4-1:0] fields;

	assign strobe = {vol_ff[PMER_SLOT_SEQUENCE_CFG_1], vol_ff[PMER_SLOT_SEQUENCE_CFG_2], vol_ff[PMER_SLOT_SEQUENCE_CFG_3],
		vol_ff[PMER_SLOT_SEQUENCE_CFG_4][7:4]};
	assign fields = strobe;

	always_comb begin
		nxt_step = step_ff;
		nxt_stmr = stmr_ff;
		if ((pwr_on && step_ff != `PMER_SEQ_LAST) || (!pwr_on && step_ff != 4'h0)) begin
			if (stmr_ff == 32'(STROBE_CYCLES - 1)) begin
				nxt_stmr = 32'h0;
				nxt_step = pwr_on ? 4'(step_ff + 4'h1) : 4'(step_ff - 4'h1);
			end else begin
				nxt_stmr = stmr_ff + 32'h1;
			end
		end else begin
			nxt_stmr = 32'h0;
		end
	end

	genvar r;
	generate
		for (r = 0; r < PMER_NRAIL; r++) begin : g_rail
			logic [3:0] sel;
			logic en;
			assign sel = fields[(PMER_NRAIL-1-r)*4 +: 4];
			assign en = vol_ff[PMER_SLOT_EN][PMER_RAIL_EN_BIT[r]];
			// Excluded rails follow their enable bit alone
			assign nxt_rail[PMER_NRAIL-1-r] = (sel == `PMER_SEQ_EXCLUDED) ? en :
				(en && step_ff >= sel);
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_ff <= 4'h0;
			stmr_ff <= 32'h0;
			rail_ff <= '0;
		end else begin
			step_ff <= nxt_step;
			stmr_ff <= nxt_stmr;
			rail_ff <= nxt_rail;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_ff;
	assign rail_on_o = rail_ff;
	assign rail_strobe_o = strobe;
	assign live_regs_o = vol_ff;
	assign prog_mode_o = prog_ff;
	assign nvm_busy_o = nvm_busy;
endmodule // pmer_top

// file: design/pmer_top_end.sv
// Holds no logic; the block is complete without it.

// file: test/pmer_top_props.sv
// Port-level checks of the NVM reprogram block top.
// Assumes it is bound into pmer_top with the top's count parameters.
`include "pmer_cfg.svh"

module pmer_top_props
	import pmer_pkg::*;
#(
	parameter int PROG_CYCLES = 20,
	parameter int STROBE_CYCLES = 8
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// I2C pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Events
	input wire logic uv_fault_i,
	input wire logic power_cycle_i,
	input wire logic power_on_i,
	// Rail side
	input wire logic [PMER_NRAIL-1:0] rail_on_o,
	input wire pmer_rail_strobe_t rail_strobe_o,
	input wire pmer_image_t live_regs_o,
	input wire logic prog_mode_o,
	input wire logic nvm_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Commit length counter and assertions
	// ********
	int busy_cnt_ff;
	int nxt_busy_cnt;
	always_comb begin
		nxt_busy_cnt = nvm_busy_o ? busy_cnt_ff + 1 : 0;
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_cnt_ff <= 0;
		end else begin
			busy_cnt_ff <= nxt_busy_cnt;
		end
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// Field copy is combinational with no lag; the stable-image guard skips cycles in which the registers change
	seq_fields_a: assert property ($stable(live_regs_o) |->
		rail_strobe_o[27:4] == {live_regs_o[PMER_SLOT_SEQUENCE_CFG_1], live_regs_o[PMER_SLOT_SEQUENCE_CFG_2],
		live_regs_o[PMER_SLOT_SEQUENCE_CFG_3]})
		else $error("strobe fields differ from sequence registers");
	sw2_field_a: assert property ($stable(live_regs_o) |->
		rail_strobe_o.second_switch_rail == live_regs_o[PMER_SLOT_SEQUENCE_CFG_4][7:4])
		else $error("second switch field differs from its register");
	uv_reload_a: assert property ($rose(uv_fault_i) |-> ##5
		(live_regs_o[0] & ~`PMER_MASK_BUCK1) == (`PMER_DEF_BUCK1 & ~`PMER_MASK_BUCK1))
		else $error("volatile setpoint bit not restored after undervoltage");
	pc_reload_a: assert property ($rose(power_cycle_i) |-> ##5 (!prog_mode_o &&
		(live_regs_o[3] & ~`PMER_MASK_SLEW) == (`PMER_DEF_SLEW & ~`PMER_MASK_SLEW)))
		else $error("volatile bits not restored after power cycle");
	commit_busy_a: assert property ($rose(prog_mode_o) |-> ##[1:3] nvm_busy_o)
		else $error("commit did not start");
	busy_bound_a: assert property (nvm_busy_o |-> busy_cnt_ff <= PROG_CYCLES + 1)
		else $error("commit runs too long");
	busy_len_a: assert property ($fell(nvm_busy_o) |-> busy_cnt_ff >= PROG_CYCLES - 1)
		else $error("commit ended too early");
	excluded_rail_a: assert property (($stable(live_regs_o) &&
		rail_strobe_o.linreg3_strobe_select == `PMER_SEQ_EXCLUDED) |=>
		rail_on_o[1] == $past(live_regs_o[PMER_SLOT_EN][`PMER_EN_BIT_LIN3]))
		else $error("excluded rail does not follow its enable bit");
	gated_rail_a: assert property (($stable(live_regs_o) &&
		!live_regs_o[PMER_SLOT_EN][`PMER_EN_BIT_BUCK1]) |=> !rail_on_o[6])
		else $error("disabled rail is on");
	ack_phase_a: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("data line pulled while clock high");
	uv_c: cover property ($rose(uv_fault_i));
	commit_c: cover property ($fell(nvm_busy_o));
	pc_c: cover property ($rose(power_cycle_i));
	all_on_c: cover property (rail_on_o == 7'h7F);
endmodule // pmer_top_props

bind pmer_top pmer_top_props #(.PROG_CYCLES(PROG_CYCLES), .STROBE_CYCLES(STROBE_CYCLES)) u_props (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .uv_fault_i(uv_fault_i), .power_cycle_i(power_cycle_i),
	.power_on_i(power_on_i), .rail_on_o(rail_on_o), .rail_strobe_o(rail_strobe_o),
	.live_regs_o(live_regs_o), .prog_mode_o(prog_mode_o), .nvm_busy_o(nvm_busy_o)
);

// file: test/pmer_host_model.sv
// I2C host model for the register pins of the reprogram block.
// Assumes the bench resolves the open-drain data line with a pull-up.
`include "pmer_cfg.svh"

module pmer_host_model
	import pmer_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Bus pins
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o,
	// Read results
	output logic rd_valid_o,
	output pmer_byte_t rd_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Bit, frame and register tasks
	// ********
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_data_o = 8'h00;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// Data moves a quarter phase after the clock fall, never beside it
	task automatic bit_out(input logic b);
		sda_pull_o = ~b;
		wt(3);
		scl_o = 1'b1;
		wt(6);
		scl_o = 1'b0;
		wt(3);
	endtask
	task automatic bit_in(output logic b);
		sda_pull_o = 1'b0;
		wt(3);
		scl_o = 1'b1;
		wt(3);
		b = sda_i;
		wt(3);
		scl_o = 1'b0;
		wt(3);
	endtask
	task automatic frame_start();
		sda_pull_o = 1'b0;
		wt(3);
		scl_o = 1'b1;
		wt(6);
		sda_pull_o = 1'b1;
		wt(6);
		scl_o = 1'b0;
		wt(3);
	endtask
	task automatic frame_stop();
		sda_pull_o = 1'b1;
		wt(3);
		scl_o = 1'b1;
		wt(6);
		sda_pull_o = 1'b0;
		wt(6);
	endtask
	task automatic put(input pmer_byte_t b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_out(b[i]);
		bit_in(a);
		ack = ~a;
	endtask
	task automatic probe(input logic [6:0] adr, output logic ack);
		frame_start();
		put({adr, 1'b0}, ack);
		frame_stop();
	endtask
	task automatic write_reg(input pmer_byte_t off, input pmer_byte_t d);
		logic a;
		frame_start();
		put({`PMER_I2C_ADDR, 1'b0}, a);
		put(off, a);
		put(d, a);
		frame_stop();
	endtask
	task automatic prot_write(input pmer_byte_t off, input pmer_byte_t d);
		write_reg(`PMER_OFF_KEY, off ^ `PMER_KEY_XOR);
		write_reg(off, d);
	endtask
	task automatic read_reg(input pmer_byte_t off);
		logic a;
		logic b;
		frame_start();
		put({`PMER_I2C_ADDR, 1'b0}, a);
		put(off, a);
		frame_start();
		put({`PMER_I2C_ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--) begin
			bit_in(b);
			rd_data_o[i] = b;
		end
		bit_out(1'b1);
		frame_stop();
		rd_valid_o = 1'b1;
		wt(1);
		rd_valid_o = 1'b0;
	endtask
endmodule // pmer_host_model

// file: test/pmer_top_tb_top.sv
// Self-checking bench of the reprogram block: host model on I2C, events from here.
// Assumes the design, the checker and the host model are compiled first.
`include "pmer_cfg.svh"

module pmer_top_tb_top
	import pmer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Signals, instances and checking
	// ********
	localparam int PROG = 20;
	localparam int STRB = 8;
	logic sys_clk;
	logic rst_n;
	logic scl;
	logic pull;
	logic oe;
	logic uv;
	logic pcyc;
	logic pon;
	logic ack;
	logic prog;
	logic busy;
	logic rd_valid;
	logic [PMER_NRAIL-1:0] rail;
	pmer_rail_strobe_t strb;
	pmer_image_t live;
	pmer_byte_t rd_data;
	pmer_byte_t d1;
	pmer_byte_t d2;
	pmer_byte_t exp_q[$];
	int failures = 0;
	int comparisons = 0;
	int busy_seen = 0;
	int seed;
	logic sda_dev;
	// Open-drain line with a pull-up: low while either side pulls
	wire logic sda = ~pull & (~oe | sda_dev);

	pmer_top #(.PROG_CYCLES(PROG), .STROBE_CYCLES(STRB)) dut (
		.sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_dev),
		.sda_oe_o(oe), .uv_fault_i(uv), .power_cycle_i(pcyc), .power_on_i(pon),
		.rail_on_o(rail), .rail_strobe_o(strb), .live_regs_o(live), .prog_mode_o(prog),
		.nvm_busy_o(busy)
	);
	pmer_host_model host (
		.sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull),
		.rd_valid_o(rd_valid), .rd_data_o(rd_data)
	);

	task automatic end_sim();
		if (failures == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk_port(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic chk_read(input pmer_byte_t e);
		comparisons++;
		if (rd_data !== e) begin
			failures++;
			$display("[ERR] read_data expected %0h seen %0h", e, rd_data);
		end
	endtask
	task automatic rd(input pmer_byte_t off, input pmer_byte_t e);
		exp_q.push_back(e);
		host.read_reg(off);
		host.wt(2);
	endtask
	task automatic pulse_wait();
		host.wt(8);
		uv = 1'b0;
		pcyc = 1'b0;
		host.wt(4);
	endtask

	always @(posedge sys_clk) begin
		if (rd_valid === 1'b1) begin
			chk_read(exp_q.pop_front());
		end
		if (busy === 1'b1) begin
			busy_seen++;
		end
	end
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// About 12k cycles of traffic are expected; the limit leaves wide margin
	initial begin
		#400000;
		failures++;
		end_sim();
	end
	initial begin
		seed = 32'h06c8970a;
		rst_n = 1'b0;
		uv = 1'b0;
		pcyc = 1'b0;
		pon = 1'b0;
		// Event pins bounce at random while reset holds; none of it may leak out
		repeat (5) begin
			@(negedge sys_clk);
			uv = 1'($random(seed));
			pcyc = 1'($random(seed));
			pon = 1'($random(seed));
		end
		@(negedge sys_clk);
		uv = 1'b0;
		pcyc = 1'b0;
		pon = 1'b0;
		rst_n = 1'b1;
		host.wt(4);
		for (int i = 0; i < PMER_NSLOT; i++) chk_port("reset_slot", PMER_SLOT_DEF[i], live[i]);
		chk_port("strobe_map", {8'h15, 8'h5F, 8'h32, 4'h4}, strb);
		host.probe(7'h25, ack);
		chk_port("foreign_ack", 32'h0, ack);
		d1 = 8'($random(seed)) | 8'h01;
		d2 = 8'($random(seed)) | 8'h80;
		host.prot_write(`PMER_OFF_BUCK1, d1);
		rd(`PMER_OFF_BUCK1, d1);
		host.write_reg(`PMER_OFF_KEY, `PMER_OFF_BUCK2 ^ `PMER_KEY_XOR ^ 8'h01);
		host.write_reg(`PMER_OFF_BUCK2, d2);
		rd(`PMER_OFF_BUCK2, `PMER_DEF_BUCK2);
		host.prot_write(`PMER_OFF_BUCK2, d2);
		host.write_reg(`PMER_OFF_BUCK2, ~d2);
		rd(`PMER_OFF_BUCK2, d2);
		host.prot_write(`PMER_OFF_SEQUENCE_CFG_4, 8'h70);
		chk_port("sw2_field", 32'h7, strb.second_switch_rail);
		// Volatile slew bit goes into the image so the power cycle must mask it
		host.prot_write(`PMER_OFF_SLEW, 8'h46);
		host.prot_write(`PMER_OFF_TEST, 8'h10);
		chk_port("prog_mode", 32'h1, prog);
		chk_port("busy_len", 32'h1, busy_seen >= PROG - 1 && busy_seen <= PROG + 1);
		rd(`PMER_OFF_TEST, 8'h10);
		host.prot_write(`PMER_OFF_TEST, 8'h00);
		chk_port("prog_exit", 32'h0, prog);
		host.prot_write(`PMER_OFF_BUCK1, ~d1);
		host.write_reg(`PMER_OFF_KEY, 8'hA5);
		uv = 1'b1;
		pulse_wait();
		chk_port("uv_buck1", d1 & `PMER_MASK_BUCK1, live[0]);
		rd(`PMER_OFF_KEY, 8'h00);
		host.prot_write(`PMER_OFF_EN, 8'h00);
		rd(`PMER_OFF_EN, 8'h00);
		rd(`PMER_OFF_SLEW, 8'h46);
		pcyc = 1'b1;
		pulse_wait();
		chk_port("pc_slew", `PMER_DEF_SLEW, live[3]);
		chk_port("pc_enable", `PMER_DEF_EN, live[PMER_SLOT_EN]);
		chk_port("pc_sw2", 32'h7, strb.second_switch_rail);
		host.prot_write(`PMER_OFF_SEQUENCE_CFG_3, 8'h30);
		host.wt(200);
		chk_port("rails_step0", 32'h02, rail);
		pon = 1'b1;
		host.wt(200);
		chk_port("rails_top", 32'h7F, rail);
		host.prot_write(`PMER_OFF_EN, 8'h3E);
		host.wt(4);
		chk_port("rails_gated", 32'h79, rail);
		end_sim();
	end
endmodule // pmer_top_tb_top
